// >>> design/tmxa_consts.svh
// Purpose: Constants for the TDM multiplex alignment block
// Assumes: Included by the alignment package users only
// Notes: Byte address of each register is four times its index
// Function
// [R1] Register at index 0x04, reset zero, nibble per input line 0-3: loop, dir, step.
// [R2] Register at index 0x06, reset zero, same layout for input lines 4-7.
// [R3] Step 00 samples each bit at three quarters, frame sync marks bit one; the code restarts bit_cnt_q at bit 0.
// [R4] Input direction one delays sampling half, one or two bit-times.
// [R5] Input direction zero advances sampling half, one or two bit-times.
// [R6] Without min-delay increase, input delay requests are ignored.
// [R7] Half bit-time is 244 ns at 2048 kHz, 122 ns at 4096 kHz.
// [R8] Loopback feeds output line i to the matrix instead of input line i.
// [R9] Looped output reaches the external pin only when its enable is set.
// [R10] Software keeps step bits zero on lines 4 and 5 carrying GCI.
// [R11] Register at index 0x08, reset zero, nibble per output line 0-3: enable, dir, step.
// [R12] Register at index 0x0a, reset zero, same layout for output lines 4-7.
// [R13] Step 00 launches on double-clock rising edge, bit 0 from frame sync.
// [R14] Output direction one delays launch half, one or two bit-times.
// [R15] Output direction zero advances launch half, one or two bit-times.
// [R16] Without min-delay increase, output advance requests are ignored.
// [R17] Output pin driven only while enabled, otherwise high impedance.
// [R18] Minimum matrix delay is three slots with increase set, else two.
// [R19] All positions derive from the double-rate clock aligned to frame sync.
`ifndef TMXA_CONSTS_SVH
`define TMXA_CONSTS_SVH
`define TMXA_IDX_IN_LO 8'h04
`define TMXA_IDX_IN_HI 8'h06
`define TMXA_IDX_OUT_LO 8'h08
`define TMXA_IDX_OUT_HI 8'h0a
`define TMXA_IDX_MATRIX 8'h0c
`define TMXA_IDX_STATUS 8'h0e
`define TMXA_RST_CFG 16'h0000
`define TMXA_HALF_BIT_2M_NS 244
`define TMXA_HALF_BIT_4M_NS 122
`define TMXA_CORE_PERIOD_NS 5
`define TMXA_TAP_BASE 5'h08
`define TMXA_Q_SAMPLE 2'h2
`define TMXA_Q_LAST 2'h3
`define TMXA_RESP_OK 2'h0
`define TMXA_RESP_ERR 2'h2
`define TMXA_SLOTS_MIN 2'h2
`define TMXA_SLOTS_INC 2'h3
`endif

// >>> design/tmxa_pkg.sv
// Purpose: Types for the TDM multiplex alignment block
// Assumes: Constants come from tmxa_consts.svh
// Notes: One nibble describes one line
package tmxa_pkg;
   // Per-line nibble, top bit first
   typedef struct packed {
      logic line_ctl; // Loopback for inputs, enable for outputs
      logic shift_direction_select;
      logic shift_step_high;
      logic shift_step_low;
   } tmxa_nib_t;
   typedef struct packed {
      logic [7:0] idx;
      logic [15:0] data;
      logic [1:0] strb;
   } tmxa_wr_t;
endpackage : tmxa_pkg

// >>> design/tmxa_align.sv
// Purpose: Bit alignment of eight TDM inputs and outputs around the switch matrix
// Assumes: lclk is the double-rate bit clock, asynchronous to core_clk
// Notes: Registers over AXI4-Lite, byte address is four times the index
`timescale 1ns/100ps
`default_nettype none
`include "tmxa_consts.svh"
module tmxa_align #(
   parameter int LINES = 8,
   parameter int FRAME_BITS = 256
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic lclk,
   input wire logic frame_sync,
   input wire logic [LINES-1:0] din,
   output logic [LINES-1:0] dout_o,
   output logic [LINES-1:0] dout_oe,
   output logic [LINES-1:0] mx_rx_bit,
   output logic mx_rx_valid,
   input wire logic [LINES-1:0] mx_tx_bit,
   output logic mx_tx_take,
   output logic [1:0] min_delay_slots
);
   // Link clock supervision window, longest half bit rounds down
   localparam int HB2_CYC = `TMXA_HALF_BIT_2M_NS / `TMXA_CORE_PERIOD_NS;
   localparam int HB4_CYC = `TMXA_HALF_BIT_4M_NS / `TMXA_CORE_PERIOD_NS;
   localparam int BCW = $clog2(FRAME_BITS);

   // =====================================================
   // Register file
   logic [15:0] in_lo_q, in_hi_q, out_lo_q, out_hi_q;
   logic min_delay_increase_q, rate_4m_q;
   logic [7:0] aw_idx_q, ar_idx_q;
   logic aw_have_q, w_have_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   tmxa_pkg::tmxa_wr_t wr;
   logic wr_fire, wr_hit;
   logic link_ok_q;
   logic [BCW-1:0] bit_cnt_q;

   // Write address and data may arrive in either order; one write at a time
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_idx_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TMXA_RESP_OK;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_idx_q <= {2'h0, s_axi_awaddr[7:2]};
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `TMXA_RESP_OK : `TMXA_RESP_ERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Decode of a complete write
   always_comb begin
      wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
      wr.idx = aw_idx_q;
      wr.data = wdata_q[15:0];
      wr.strb = wstrb_q[1:0];
      wr_hit = (wr.idx == `TMXA_IDX_IN_LO) || (wr.idx == `TMXA_IDX_IN_HI) ||
               (wr.idx == `TMXA_IDX_OUT_LO) || (wr.idx == `TMXA_IDX_OUT_HI) ||
               (wr.idx == `TMXA_IDX_MATRIX) || (wr.idx == `TMXA_IDX_STATUS);
   end

   function automatic logic [15:0] merge(input logic [15:0] old, input tmxa_pkg::tmxa_wr_t w);
      merge = {w.strb[1] ? w.data[15:8] : old[15:8], w.strb[0] ? w.data[7:0] : old[7:0]};
   endfunction

   // Configuration storage, byte lanes honoured
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         in_lo_q <= `TMXA_RST_CFG; // R1
         in_hi_q <= `TMXA_RST_CFG; // R2
         out_lo_q <= `TMXA_RST_CFG; // R11
         out_hi_q <= `TMXA_RST_CFG; // R12
         min_delay_increase_q <= 1'b0;
         rate_4m_q <= 1'b0;
      end else if (wr_fire) begin
         if (wr.idx == `TMXA_IDX_IN_LO) in_lo_q <= merge(in_lo_q, wr); // R1
         if (wr.idx == `TMXA_IDX_IN_HI) in_hi_q <= merge(in_hi_q, wr); // R2
         if (wr.idx == `TMXA_IDX_OUT_LO) out_lo_q <= merge(out_lo_q, wr); // R11
         if (wr.idx == `TMXA_IDX_OUT_HI) out_hi_q <= merge(out_hi_q, wr); // R12
         if (wr.idx == `TMXA_IDX_MATRIX && wr.strb[0]) begin
            min_delay_increase_q <= wr.data[0];
            rate_4m_q <= wr.data[1];
         end
      end
   end

   // Read channel; unmapped index answers SLVERR with zero data
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `TMXA_RESP_OK;
         ar_idx_q <= 8'h00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         ar_idx_q <= {2'h0, s_axi_araddr[7:2]};
         s_axi_rresp <= `TMXA_RESP_OK;
         unique case ({2'h0, s_axi_araddr[7:2]})
            `TMXA_IDX_IN_LO: s_axi_rdata <= {16'h0000, in_lo_q};
            `TMXA_IDX_IN_HI: s_axi_rdata <= {16'h0000, in_hi_q};
            `TMXA_IDX_OUT_LO: s_axi_rdata <= {16'h0000, out_lo_q};
            `TMXA_IDX_OUT_HI: s_axi_rdata <= {16'h0000, out_hi_q};
            `TMXA_IDX_MATRIX: s_axi_rdata <= {30'h0000_0000, rate_4m_q, min_delay_increase_q};
            `TMXA_IDX_STATUS: s_axi_rdata <= {15'h0000, link_ok_q, 16'(bit_cnt_q)};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `TMXA_RESP_ERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // =====================================================
   // Link side synchronisers and edge finding
   logic lclk_s1, lclk_s2, lclk_d, fs_s1, fs_s2;
   logic [LINES-1:0] din_s1, din_s2;
   logic edge_any, edge_rise;
   logic [1:0] q_q;
   logic [7:0] watch_q;

   // Two flops on every pin before logic reads it
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         lclk_s1 <= 1'b0;
         lclk_s2 <= 1'b0;
         lclk_d <= 1'b0;
         fs_s1 <= 1'b0;
         fs_s2 <= 1'b0;
         din_s1 <= '0;
         din_s2 <= '0;
      end else begin
         lclk_s1 <= lclk;
         lclk_s2 <= lclk_s1;
         lclk_d <= lclk_s2;
         fs_s1 <= frame_sync;
         fs_s2 <= fs_s1;
         din_s1 <= din;
         din_s2 <= din_s1;
      end
   end

   // Both edges of the double-rate clock give quarter-bit ticks
   assign edge_any = lclk_s2 ^ lclk_d; // R19
   assign edge_rise = lclk_s2 & ~lclk_d;

   // Quarter phase and bit position; frame sync on a rising edge restarts both
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q_q <= 2'h0;
         bit_cnt_q <= '0;
      end else if (edge_rise && fs_s2) begin
         q_q <= 2'h0; // R3 R13 R19
         bit_cnt_q <= '0;
      end else if (edge_any) begin
         q_q <= q_q + 2'h1;
         if (q_q == `TMXA_Q_LAST) bit_cnt_q <= (bit_cnt_q == BCW'(FRAME_BITS - 1)) ? '0 : bit_cnt_q + 1'b1;
      end
   end

   // Link clock supervision: no edge for two half bits means lost clock
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         watch_q <= 8'h00;
         link_ok_q <= 1'b0;
      end else if (edge_any) begin
         watch_q <= 8'h00;
         link_ok_q <= 1'b1;
      end else if (watch_q == 8'(2 * (rate_4m_q ? HB4_CYC : HB2_CYC))) begin
         link_ok_q <= 1'b0; // R7
      end else begin
         watch_q <= watch_q + 8'h01;
      end
   end

   // =====================================================
   // Per-line alignment
   // Tap in quarter ticks; a fixed two-bit base lets advances look back in time
   function automatic logic [4:0] tap(input tmxa_pkg::tmxa_nib_t n, input logic allow_del,
                                      input logic allow_adv);
      logic [4:0] mag;
      mag = 5'h00;
      unique case ({n.shift_step_high, n.shift_step_low})
         2'b00: mag = 5'h00;
         2'b01: mag = 5'h02;
         2'b10: mag = 5'h04;
         2'b11: mag = 5'h08;
      endcase
      if (n.shift_direction_select) tap = allow_del ? `TMXA_TAP_BASE + mag : `TMXA_TAP_BASE;
      else tap = allow_adv ? `TMXA_TAP_BASE - mag : `TMXA_TAP_BASE;
   endfunction

   // Bit boundary and sample tick, shared by all lines
   logic sample_tick, start_tick;
   assign sample_tick = edge_any && (q_q == `TMXA_Q_SAMPLE);
   assign start_tick = edge_any && ((q_q == `TMXA_Q_LAST) || (edge_rise && fs_s2));

   genvar gi;
   generate
      for (gi = 0; gi < LINES; gi++) begin : g_line
         tmxa_pkg::tmxa_nib_t in_n, out_n;
         logic [15:0] ihist_q, ohist_q;
         logic [16:0] iwin, owin;
         logic rx_src, tx_cur;
         logic [4:0] itap, otap;
         assign in_n = (gi < 4) ? in_lo_q[4*(gi%4) +: 4] : in_hi_q[4*(gi%4) +: 4];
         assign out_n = (gi < 4) ? out_lo_q[4*(gi%4) +: 4] : out_hi_q[4*(gi%4) +: 4];
         // A later sampling instant reads a younger history entry, so the input tap mirrors the output one
         assign itap = 5'(2 * `TMXA_TAP_BASE - tap(in_n, min_delay_increase_q, 1'b1)); // R4 R5 R6
         assign otap = tap(out_n, 1'b1, min_delay_increase_q); // R14 R15 R16
         // Loopback takes the internal output stream, whatever the pin enable
         assign rx_src = in_n.line_ctl ? dout_o[gi] : din_s2[gi]; // R8 R9
         assign tx_cur = start_tick ? mx_tx_bit[gi] : ohist_q[0];
         assign iwin = {ihist_q, rx_src};
         assign owin = {ohist_q, tx_cur};

         // Quarter-tick histories of received and launched levels
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               ihist_q <= 16'h0000;
               ohist_q <= 16'h0000;
               mx_rx_bit[gi] <= 1'b0;
               dout_o[gi] <= 1'b0;
               dout_oe[gi] <= 1'b0;
            end else begin
               if (edge_any) begin
                  ihist_q <= iwin[15:0];
                  ohist_q <= owin[15:0];
                  dout_o[gi] <= owin[otap]; // R13 R14 R15
               end
               if (sample_tick) mx_rx_bit[gi] <= iwin[itap]; // R3 R4 R5
               dout_oe[gi] <= out_n.line_ctl; // R17 R9
            end
         end
      end
   endgenerate

   // Matrix strobes and minimum throughput delay
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mx_rx_valid <= 1'b0;
         mx_tx_take <= 1'b0;
         min_delay_slots <= `TMXA_SLOTS_MIN;
      end else begin
         mx_rx_valid <= sample_tick;
         mx_tx_take <= start_tick;
         min_delay_slots <= min_delay_increase_q ? `TMXA_SLOTS_INC : `TMXA_SLOTS_MIN; // R18
      end
   end

   // =====================================================
   // Checks
   a_oe_follows_cfg: assert property (@(posedge core_clk) disable iff (!rst_n) // R17
      ##1 (dout_oe[0] == $past(out_lo_q[3]))) else $error("Output enable mismatch");
   a_oe_high_lines: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
      ##1 (dout_oe[7] == $past(out_hi_q[15]))) else $error("Line 7 enable mismatch");
   a_slots_inc: assert property (@(posedge core_clk) disable iff (!rst_n) // R18
      min_delay_increase_q ##1 min_delay_increase_q |-> min_delay_slots == 2'h3)
      else $error("Min delay not three");
   a_slots_min: assert property (@(posedge core_clk) disable iff (!rst_n) // R18
      !min_delay_increase_q ##1 !min_delay_increase_q |-> min_delay_slots == 2'h2)
      else $error("Min delay not two");
   a_rx_at_quarter: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
      mx_rx_valid |-> $past(q_q) == 2'h2) else $error("Sample off three quarters");
   a_no_in_delay: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
      !min_delay_increase_q |-> g_line[0].itap >= 5'h08) else $error("Input delayed");
   a_no_out_adv: assert property (@(posedge core_clk) disable iff (!rst_n) // R16
      !min_delay_increase_q |-> g_line[0].otap >= 5'h08) else $error("Output advanced");
   a_frame_restart: assert property (@(posedge core_clk) disable iff (!rst_n) // R19
      edge_rise && fs_s2 |=> q_q == 2'h0 && bit_cnt_q == '0) else $error("Frame not restarted");
   a_write_resp: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
      wr_fire |=> s_axi_bvalid) else $error("No write response");
   a_loop_source: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
      in_lo_q[3] |-> g_line[0].rx_src == dout_o[0]) else $error("Loopback source wrong");
   // Shift direction at step code 11; line 0 stands for the rest, all share one tap function
   a_rx_delay_tap: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
      min_delay_increase_q && in_lo_q[2:0] == 3'h7 |-> g_line[0].itap == 5'h00)
      else $error("Input delay goes the wrong way");
   a_rx_adv_tap: assert property (@(posedge core_clk) disable iff (!rst_n) // R5
      in_lo_q[2:0] == 3'h3 |-> g_line[0].itap == 5'h10) else $error("Input advance goes the wrong way");
   a_tx_delay_tap: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
      out_lo_q[2:0] == 3'h7 |-> g_line[0].otap == 5'h10) else $error("Output delay goes the wrong way");
   a_tx_adv_tap: assert property (@(posedge core_clk) disable iff (!rst_n) // R15
      min_delay_increase_q && out_lo_q[2:0] == 3'h3 |-> g_line[0].otap == 5'h00)
      else $error("Output advance goes the wrong way");
   a_tx_take_pulse: assert property (@(posedge core_clk) disable iff (!rst_n) // R13
      start_tick |=> mx_tx_take) else $error("Bit start not reported to matrix");
   c_loopback: cover property (@(posedge core_clk) disable iff (!rst_n) in_lo_q[3] && mx_rx_valid);
   c_frame: cover property (@(posedge core_clk) disable iff (!rst_n) edge_rise && fs_s2);
   c_out_delay: cover property (@(posedge core_clk) disable iff (!rst_n)
      g_line[0].otap == 5'h10 && dout_oe[0]);
   c_in_advance: cover property (@(posedge core_clk) disable iff (!rst_n)
      g_line[0].itap == 5'h10 && mx_rx_valid);
endmodule // tmxa_align
`default_nettype wire

// >>> test/tmxa_line_model.sv
// Purpose: Line transceiver model facing the alignment block
// Assumes: Double-rate bit clock runs free with an 80 ns period
// Notes: Every line carries a single one at MARK_BIT of each frame
`timescale 1ns/100ps
`default_nettype none
module tmxa_line_model #(
   parameter int LINES = 8,
   parameter int FRAME_BITS = 16,
   parameter int MARK_BIT = 8
) (
   output logic lclk,
   output logic frame_sync,
   output logic [LINES-1:0] din,
   input wire logic [LINES-1:0] dout_o,
   input wire logic [LINES-1:0] dout_oe,
   output wire logic [LINES-1:0] pin
);
   int tick;
   // ==========================================
   // Quarter-bit ticks: lclk rises on even ticks, a bit starts every fourth
   initial begin
      tick = FRAME_BITS * 4 - 1;
      lclk = 1'b0;
      frame_sync = 1'b0;
      din = '0;
      forever begin
         #40;
         tick = (tick + 1) % (FRAME_BITS * 4);
         lclk = ~tick[0];
         frame_sync = (tick == FRAME_BITS * 4 - 1) || (tick == 0);
         din = {LINES{tick / 4 == MARK_BIT}};
      end
   end
   // Pin level: released lines float, the bench sees the high impedance
   for (genvar i = 0; i < LINES; i++) begin : g_pin
      assign pin[i] = dout_oe[i] ? dout_o[i] : 1'bz;
   end
endmodule // tmxa_line_model
`default_nettype wire

// >>> test/tmxa_align_test.sv
// Purpose: Self-checking bench for the TDM alignment block
// Assumes: Frame cut to 16 bits, half bit is 80 ns on the bench link clock
// Notes: Shifts are measured against the unshifted place of one marked bit
`timescale 1ns/100ps
`default_nettype none
`include "tmxa_consts.svh"
module tmxa_align_test;
   logic core_clk, rst_n, awvalid, wvalid, bready, arvalid, rready, tx_all;
   logic awready, wready, bvalid, arready, rvalid, lclk, frame_sync, rx_valid, tx_take;
   logic [7:0] awaddr, araddr, din, dout_o, dout_oe, rx_bit, tx_bit;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, slots;
   wire logic [7:0] pin;
   int err_count, total_checks, cyc, take_n, base;
   tmxa_align #(.LINES(8), .FRAME_BITS(16)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .lclk(lclk), .frame_sync(frame_sync), .din(din), .dout_o(dout_o),
      .dout_oe(dout_oe), .mx_rx_bit(rx_bit), .mx_rx_valid(rx_valid), .mx_tx_bit(tx_bit),
      .mx_tx_take(tx_take), .min_delay_slots(slots));
   tmxa_line_model #(.LINES(8), .FRAME_BITS(16), .MARK_BIT(8)) u_line (.lclk(lclk),
      .frame_sync(frame_sync), .din(din), .dout_o(dout_o), .dout_oe(dout_oe), .pin(pin));
   // ==========================================
   // Clock, matrix feed and hang guard
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Marked bit goes out one take ahead; frame_sync still high marks bit 0
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         test_done();
      end
      if (tx_take === 1'b1) begin
         take_n = (frame_sync === 1'b1) ? 0 : take_n + 1;
         tx_bit <= (tx_all || take_n == 7) ? 8'hff : 8'h00;
      end
   end
   // ==========================================
   // Checking and bus tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Edge detection through the synchroniser jitters by a couple of cycles
   task automatic near(input int got, input int exp);
      chk((got - exp <= 12 && exp - got <= 12) ? exp : got, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic cfg(input logic [7:0] idx, input logic [15:0] v);
      logic [1:0] r;
      wr(idx << 2, {16'h0000, v}, r);
      chk(r, `TMXA_RESP_OK);
   endtask
   task automatic rxv;
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (rx_valid !== 1'b1 && n < 200);
   endtask
   // Time from a frame start to the marked bit, on the matrix or the line side
   task automatic measure(input bit tx, output int dt);
      realtime t0;
      int n;
      n = 0;
      repeat (2) @(posedge frame_sync);
      t0 = $realtime;
      while (n < 800 && !(tx ? dout_o[0] === 1'b1 : (rx_valid === 1'b1 && rx_bit[0] === 1'b1))) begin
         @(posedge core_clk);
         n++;
      end
      dt = int'($realtime - t0);
   endtask
   task automatic fin(input string s);
      $display("test %s done, mismatches so far %0d", s, err_count);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_regs;
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] idx [4] = '{`TMXA_IDX_IN_LO, `TMXA_IDX_IN_HI, `TMXA_IDX_OUT_LO, `TMXA_IDX_OUT_HI};
      chk(slots, `TMXA_SLOTS_MIN);
      foreach (idx[k]) begin
         rd(idx[k] << 2, d, r);
         chk(d, {16'h0000, `TMXA_RST_CFG});
         wr(idx[k] << 2, 32'hffff_ffff, r);
         rd(idx[k] << 2, d, r);
         chk(d, 32'h0000_ffff);
         cfg(idx[k], 16'h0000);
      end
      rd(8'h3c, d, r);
      chk(r, `TMXA_RESP_ERR);
      chk(d, 32'h0000_0000);
      wr(8'h3c, 32'h0000_1234, r);
      chk(r, `TMXA_RESP_ERR);
      fin("registers");
   endtask
   task automatic t_loop;
      chk(dout_oe, 8'h00);
      chk(pin, 8'hzz);
      tx_all <= 1'b1;
      cfg(`TMXA_IDX_OUT_LO, 16'h8888);
      cfg(`TMXA_IDX_OUT_HI, 16'h8888);
      cfg(`TMXA_IDX_IN_LO, 16'h8888);
      cfg(`TMXA_IDX_IN_HI, 16'h8888);
      repeat (2) @(posedge frame_sync);
      rxv();
      chk(rx_bit, 8'hff);
      chk(dout_oe, 8'hff);
      chk(pin, dout_o);
      cfg(`TMXA_IDX_OUT_LO, 16'h0000);
      cfg(`TMXA_IDX_OUT_HI, 16'h0000);
      repeat (2) @(posedge frame_sync);
      rxv();
      chk(rx_bit, 8'hff);
      chk(pin, 8'hzz);
      cfg(`TMXA_IDX_IN_LO, 16'h0000);
      cfg(`TMXA_IDX_IN_HI, 16'h0000);
      tx_all <= 1'b0;
      // Two frames flush the looped-back ones out of the sampling history
      repeat (2) @(posedge frame_sync);
      rxv();
      chk(rx_bit, 8'h00);
      fin("loopback");
   endtask
   task automatic t_shift(input bit tx);
      int dt, qtr;
      logic [7:0] ix;
      ix = tx ? `TMXA_IDX_OUT_LO : `TMXA_IDX_IN_LO;
      cfg(`TMXA_IDX_MATRIX, 16'h0001);
      // Slot count is registered one edge behind the write
      @(posedge core_clk);
      chk(slots, `TMXA_SLOTS_INC);
      measure(tx, base);
      for (int s = 1; s < 4; s++) begin
         for (int dl = 0; dl < 2; dl++) begin
            cfg(ix, 16'(dl * 4 + s));
            measure(tx, dt);
            // Shift in 40 ns quarter ticks, later is positive
            qtr = (dl ? 2 : -2) * (s == 3 ? 4 : s);
            // Line side moves by the shift; matrix side by whole 160 ns bits crossed from the 3/4 point
            if (tx) near(dt, base + 40 * qtr);
            else near(dt, base - 160 * ((19 + qtr) / 4 - 4));
         end
      end
      cfg(`TMXA_IDX_MATRIX, 16'h0000);
      @(posedge core_clk);
      chk(slots, `TMXA_SLOTS_MIN);
      cfg(ix, tx ? 16'h0003 : 16'h0007);
      measure(tx, dt);
      near(dt, base);
      cfg(ix, 16'h0000);
      fin(tx ? "transmit shift" : "receive shift");
   endtask
   // ==========================================
   // Main sequence
   initial begin
      {rst_n, awvalid, wvalid, bready, arvalid, rready, tx_all} = '0;
      {awaddr, araddr, wdata, wstrb, tx_bit} = '0;
      {err_count, total_checks, cyc, take_n} = '0;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      t_regs();
      t_loop();
      t_shift(1'b0);
      t_shift(1'b1);
      test_done();
   end
endmodule // tmxa_align_test
`default_nettype wire
